/* core/slcc_params.svh */
// Purpose: Named constants for the strap latch and crossover control block
// Assumes: 50 MHz reference clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
`ifndef SLCC_PARAMS_SVH
`define SLCC_PARAMS_SVH

// Management register map
`define SLCC_REG_PHY_CONTROL  5'h10
`define SLCC_BIT_AUTO_OFF     6
`define SLCC_BIT_FORCE_X      5
`define SLCC_CTRL_RESET       16'h0000
`define SLCC_READ_IDLE        16'h0000

// Strap sampling
`define SLCC_SYNC_WAIT        2'h2
`define SLCC_ADDR_DEFAULT     2'h0

// Timing
`define SLCC_CLK_HZ           50000000
`define SLCC_AN_MAX_S         3
`define SLCC_NP_EXTRA_MS      100
`define SLCC_HUNT_MS          62
`define SLCC_CNT_ZERO         28'h0000000
`define SLCC_CNT_ONE          28'h0000001

`endif

/* core/slcc_pkg.sv */
// Purpose: Types shared by the strap latch and crossover control block
// Assumes: Constants come from slcc_params.svh
// Notes:   Nothing here is imported; users write slcc_pkg::name
package slcc_pkg;

    // Crossover resolution states, one-hot
    typedef enum logic [3:0] {
        SLCC_X_IDLE = 4'h1,
        SLCC_X_MDI  = 4'h2,
        SLCC_X_MDIX = 4'h4,
        SLCC_X_LOCK = 4'h8
    } slcc_xover_state_type;

    typedef logic [1:0] slcc_mode_type;

    // Four-level strap: comparator thermometer code to mode 0..3
    function automatic slcc_mode_type slcc_decode4(input logic [2:0] therm);
        if (therm[2]) begin
            return 2'h3;
        end else if (therm[1]) begin
            return 2'h2;
        end else if (therm[0]) begin
            return 2'h1;
        end
        return 2'h0;
    endfunction : slcc_decode4

endpackage : slcc_pkg

/* core/slcc_strap_if.sv */
// Purpose: Carries latched strap values from the latch to the top
// Assumes: One clock domain
// Notes:   valid rises once after each hard reset
`timescale 1ns/1ps
interface slcc_strap_if;
    logic                  valid;
    slcc_pkg::slcc_mode_type addr_low;
    slcc_pkg::slcc_mode_type addr_high;
    logic                  auto_off;
    logic                  force_x;

    modport source (output valid, addr_low, addr_high, auto_off, force_x);
    modport sink   (input  valid, addr_low, addr_high, auto_off, force_x);
endinterface : slcc_strap_if

/* core/slcc_strap_latch.sv */
// Purpose: Synchronises, decodes and latches the strap pins once per hard reset
// Assumes: Pins are static around reset release
// Notes:   Values hold until the next hard reset; later pin activity is ignored
`timescale 1ns/1ps
`include "slcc_params.svh"
module slcc_strap_latch (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    // Strap pins
    input  wire logic [2:0] receive_data_bit_zero_pin_i,
    input  wire logic [2:0] receive_data_bit_one_pin_i,
    input  wire logic       crossover_auto_off_strap_i,
    input  wire logic       crossover_force_strap_i,
    // Latched values
    slcc_strap_if.source    strap
);

    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [1:0] wait_reg;

    // Two-stage synchroniser on all strap pins
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else begin
            sync1_reg <= {receive_data_bit_zero_pin_i, receive_data_bit_one_pin_i,
                          crossover_auto_off_strap_i, crossover_force_strap_i};
            sync2_reg <= sync1_reg;
        end
    end

    // Wait for the synchroniser to fill after release
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wait_reg <= `SLCC_SYNC_WAIT;
        end else if (wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
        end
    end

    // One capture per hard reset, then frozen
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            strap.valid     <= 1'b0;
            strap.addr_low  <= `SLCC_ADDR_DEFAULT;
            strap.addr_high <= `SLCC_ADDR_DEFAULT;
            strap.auto_off  <= 1'b0;
            strap.force_x   <= 1'b0;
        end else if (wait_reg == 2'h0 && !strap.valid) begin
            strap.valid     <= 1'b1;
            strap.addr_low  <= slcc_pkg::slcc_decode4(sync2_reg[7:5]);
            strap.addr_high <= slcc_pkg::slcc_decode4(sync2_reg[4:2]);
            strap.auto_off  <= sync2_reg[1];
            strap.force_x   <= sync2_reg[0];
        end
    end

    property p_latch_stable;
        @(posedge ref_clk_i) disable iff (reset_i)
        $past(strap.valid) |-> $stable({strap.addr_low, strap.addr_high, strap.auto_off, strap.force_x});
    endproperty
    a_latch_stable: assert property (p_latch_stable) else $error("strap values moved after capture");

    property p_sample_after_reset;
        @(posedge ref_clk_i) $fell(reset_i) |-> ##[1:4] strap.valid;
    endproperty
    a_sample_after_reset: assert property (p_sample_after_reset) else $error("straps not sampled after reset");

endmodule : slcc_strap_latch

/* core/slcc_top.sv */
// Purpose: Strap latch, control register and automatic crossover resolution
// Assumes: Comparator thermometer codes arrive for the four-level straps
// Notes:   Long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`include "slcc_params.svh"

// Behaviour
// - Flag auto-negotiation still running beyond three seconds after start.
// - Each next page exchanged extends the allowed negotiation time.
// - Automatic crossover swaps pairs A/B, and C/D in gigabit mode.
// - Permit link pulse bursts only after crossover is resolved.
// - Control bit 6 or its strap turns automatic crossover off.
// - With automatic crossover off, the mapping is fixed and never hunts.
// - Control bit 5 or its strap picks forced straight or crossed.
// - Crossover resolution runs regardless of negotiation or forced speed.
// - Sample all straps at power-up and hard reset.
// - Software reset reloads strap settings from latched values only.
// - Software may overwrite strap settings through the control register.
// - Two receive-data straps are four-level, others two-level.
// - Station address low and high pairs follow the two straps, default 00.
module slcc_top #(
    parameter int HUNT_CYCLES = `SLCC_HUNT_MS * (`SLCC_CLK_HZ / 1000),
    parameter int AN_CYCLES   = `SLCC_AN_MAX_S * `SLCC_CLK_HZ,
    parameter int NP_CYCLES   = `SLCC_NP_EXTRA_MS * (`SLCC_CLK_HZ / 1000)
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        soft_reset_i,
    // Strap pins
    input  wire logic [2:0]  receive_data_bit_zero_pin_i,
    input  wire logic [2:0]  receive_data_bit_one_pin_i,
    input  wire logic        crossover_auto_off_strap_i,
    input  wire logic        crossover_force_strap_i,
    // Management register port
    input  wire logic [4:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_write_i,
    output logic      [15:0] reg_rdata_o,
    // Line side
    input  wire logic        signal_detect_i,
    input  wire logic        gigabit_mode_i,
    // Negotiation engine
    input  wire logic        an_begin_i,
    input  wire logic        an_done_i,
    input  wire logic        next_page_i,
    // Status and control outputs
    output logic      [3:0]  station_address_o,
    output logic             swap_ab_o,
    output logic             swap_cd_o,
    output logic             flp_permit_o,
    output logic             an_overtime_o
);

    slcc_strap_if strap ();

    logic [15:0]                    phy_control_reg;
    logic [15:0]                    rdata_reg;
    logic                           valid_d_reg;
    logic                           sig_s1_reg;
    logic                           sig_s2_reg;
    slcc_pkg::slcc_xover_state_type state_reg;
    slcc_pkg::slcc_xover_state_type state_next;
    logic [27:0]                    hunt_cnt_reg;
    logic                           mdix_reg;
    logic                           swap_cd_reg;
    logic                           an_active_reg;
    logic [27:0]                    an_cnt_reg;
    logic [27:0]                    an_limit_reg;
    logic                           an_overtime_reg;
    logic                           strap_load;
    logic                           auto_on;
    logic                           force_x;
    logic                           hunt_end;

    // Saturating counter step, shared by the hunt and negotiation timers
    function automatic logic [27:0] cnt_step(input logic [27:0] v);
        return (v == 28'hFFFFFFF) ? v : v + `SLCC_CNT_ONE;
    endfunction : cnt_step

    slcc_strap_latch u_latch (
        .ref_clk_i                   (ref_clk_i),
        .reset_i                     (reset_i),
        .receive_data_bit_zero_pin_i (receive_data_bit_zero_pin_i),
        .receive_data_bit_one_pin_i  (receive_data_bit_one_pin_i),
        .crossover_auto_off_strap_i  (crossover_auto_off_strap_i),
        .crossover_force_strap_i     (crossover_force_strap_i),
        .strap                       (strap.source)
    );

    // First capture after hard reset, or software reset, reloads strap bits
    assign strap_load = (strap.valid && !valid_d_reg) || (soft_reset_i && strap.valid);
    assign auto_on    = !phy_control_reg[`SLCC_BIT_AUTO_OFF];
    assign force_x    = phy_control_reg[`SLCC_BIT_FORCE_X];
    assign hunt_end   = (hunt_cnt_reg == 28'(HUNT_CYCLES - 1));

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            valid_d_reg <= 1'b0;
        end else begin
            valid_d_reg <= strap.valid;
        end
    end

    // Control register: strap reload wins over a software write
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            phy_control_reg <= `SLCC_CTRL_RESET;
        end else if (strap_load) begin
            phy_control_reg                    <= `SLCC_CTRL_RESET;
            phy_control_reg[`SLCC_BIT_AUTO_OFF] <= strap.auto_off;
            phy_control_reg[`SLCC_BIT_FORCE_X]  <= strap.force_x;
        end else if (reg_write_i && reg_addr_i == `SLCC_REG_PHY_CONTROL) begin
            phy_control_reg <= reg_wdata_i;
        end
    end

    // Read data, zero for unmapped addresses
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_reg <= `SLCC_READ_IDLE;
        end else if (reg_addr_i == `SLCC_REG_PHY_CONTROL) begin
            rdata_reg <= phy_control_reg;
        end else begin
            rdata_reg <= `SLCC_READ_IDLE;
        end
    end

    // Line energy comes from the analog side: two flip-flops
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sig_s1_reg <= 1'b0;
            sig_s2_reg <= 1'b0;
        end else begin
            sig_s1_reg <= signal_detect_i;
            sig_s2_reg <= sig_s1_reg;
        end
    end

    // Crossover state; independent of negotiation and forced speed
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            slcc_pkg::SLCC_X_IDLE: begin
                if (strap.valid) begin
                    state_next = auto_on ? slcc_pkg::SLCC_X_MDI : slcc_pkg::SLCC_X_LOCK;
                end
            end
            slcc_pkg::SLCC_X_MDI: begin
                if (!auto_on || sig_s2_reg) begin
                    state_next = slcc_pkg::SLCC_X_LOCK;
                end else if (hunt_end) begin
                    state_next = slcc_pkg::SLCC_X_MDIX;
                end
            end
            slcc_pkg::SLCC_X_MDIX: begin
                if (!auto_on || sig_s2_reg) begin
                    state_next = slcc_pkg::SLCC_X_LOCK;
                end else if (hunt_end) begin
                    state_next = slcc_pkg::SLCC_X_MDI;
                end
            end
            slcc_pkg::SLCC_X_LOCK: begin
                if (auto_on && !sig_s2_reg) begin
                    state_next = slcc_pkg::SLCC_X_MDI;
                end
            end
            default: begin
                state_next = slcc_pkg::SLCC_X_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i || soft_reset_i) begin
            state_reg <= slcc_pkg::SLCC_X_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Hunt slot timer, restarted on every state change
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || state_next != state_reg) begin
            hunt_cnt_reg <= `SLCC_CNT_ZERO;
        end else begin
            hunt_cnt_reg <= cnt_step(hunt_cnt_reg);
        end
    end

    // Channel mapping; forced mapping when automatic crossover is off
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            mdix_reg <= 1'b0;
        end else if (!auto_on) begin
            mdix_reg <= force_x;
        end else if (state_next == slcc_pkg::SLCC_X_MDI) begin
            mdix_reg <= 1'b0;
        end else if (state_next == slcc_pkg::SLCC_X_MDIX) begin
            mdix_reg <= 1'b1;
        end
    end

    // C/D swap only applies in gigabit mode
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            swap_cd_reg <= 1'b0;
        end else begin
            swap_cd_reg <= mdix_reg && gigabit_mode_i;
        end
    end

    // Negotiation window: start, stop and next-page extension
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            an_active_reg <= 1'b0;
            an_cnt_reg    <= `SLCC_CNT_ZERO;
            an_limit_reg  <= 28'(AN_CYCLES);
        end else if (an_begin_i) begin
            an_active_reg <= 1'b1;
            an_cnt_reg    <= `SLCC_CNT_ZERO;
            an_limit_reg  <= 28'(AN_CYCLES);
        end else if (an_active_reg) begin
            an_active_reg <= !an_done_i;
            an_cnt_reg    <= cnt_step(an_cnt_reg);
            if (next_page_i) begin
                an_limit_reg <= an_limit_reg + 28'(NP_CYCLES);
            end
        end
    end

    // Overtime flag: set wins over the clear at a new start
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            an_overtime_reg <= 1'b0;
        end else if (an_active_reg && an_cnt_reg >= an_limit_reg) begin
            an_overtime_reg <= 1'b1;
        end else if (an_begin_i) begin
            an_overtime_reg <= 1'b0;
        end
    end

    // Outputs
    assign reg_rdata_o       = rdata_reg;
    assign station_address_o = {strap.addr_high, strap.addr_low};
    assign swap_ab_o         = mdix_reg;
    assign swap_cd_o         = swap_cd_reg;
    assign flp_permit_o      = (state_reg == slcc_pkg::SLCC_X_LOCK);
    assign an_overtime_o     = an_overtime_reg;

    property p_auto_off_locks;
        @(posedge ref_clk_i) disable iff (reset_i || soft_reset_i)
        (!auto_on && state_reg != slcc_pkg::SLCC_X_IDLE) |=> state_reg == slcc_pkg::SLCC_X_LOCK;
    endproperty
    a_auto_off_locks: assert property (p_auto_off_locks) else $error("crossover hunts while disabled");

    property p_forced_map;
        @(posedge ref_clk_i) disable iff (reset_i)
        (!auto_on && !$past(auto_on) && $stable(force_x)) |-> swap_ab_o == force_x;
    endproperty
    a_forced_map: assert property (p_forced_map) else $error("forced mapping not applied");

    property p_hunt_switch;
        @(posedge ref_clk_i) disable iff (reset_i || soft_reset_i)
        (state_reg == slcc_pkg::SLCC_X_MDI && hunt_end && auto_on && !sig_s2_reg)
            |=> (state_reg == slcc_pkg::SLCC_X_MDIX && swap_ab_o);
    endproperty
    a_hunt_switch: assert property (p_hunt_switch) else $error("hunt did not swap pairs");

    property p_cd_swap;
        @(posedge ref_clk_i) disable iff (reset_i)
        ##1 swap_cd_o == ($past(swap_ab_o) && $past(gigabit_mode_i));
    endproperty
    a_cd_swap: assert property (p_cd_swap) else $error("C/D swap wrong");

    property p_flp_after_resolve;
        @(posedge ref_clk_i) disable iff (reset_i)
        $rose(flp_permit_o) |-> strap.valid && ($past(sig_s2_reg) || !$past(auto_on));
    endproperty
    a_flp_after_resolve: assert property (p_flp_after_resolve) else $error("pulses before resolution");

    property p_soft_reload;
        @(posedge ref_clk_i) disable iff (reset_i)
        (soft_reset_i && strap.valid) |=> (phy_control_reg[`SLCC_BIT_AUTO_OFF] == strap.auto_off
            && phy_control_reg[`SLCC_BIT_FORCE_X] == strap.force_x);
    endproperty
    a_soft_reload: assert property (p_soft_reload) else $error("soft reset did not reload straps");

    property p_reg_write;
        @(posedge ref_clk_i) disable iff (reset_i)
        (reg_write_i && reg_addr_i == `SLCC_REG_PHY_CONTROL && !strap_load)
            |=> ##1 reg_rdata_o == $past(reg_wdata_i, 2) || $past(reg_addr_i) != `SLCC_REG_PHY_CONTROL;
    endproperty
    a_reg_write: assert property (p_reg_write) else $error("control write not visible");

    property p_overtime;
        @(posedge ref_clk_i) disable iff (reset_i)
        (an_active_reg && an_cnt_reg >= an_limit_reg) |=> an_overtime_o;
    endproperty
    a_overtime: assert property (p_overtime) else $error("overtime not flagged");

    property p_next_page;
        @(posedge ref_clk_i) disable iff (reset_i)
        (an_active_reg && next_page_i && !an_begin_i) |=> an_limit_reg == $past(an_limit_reg) + 28'(NP_CYCLES);
    endproperty
    a_next_page: assert property (p_next_page) else $error("next page did not extend window");

endmodule : slcc_top

/* dv/slcc_link_partner.sv */
// Purpose: Behavioural far-end station seen over the twisted-pair cable
// Assumes: The cable is straight or crossed, chosen by the bench
// Notes:   Energy is only seen once the local pairing matches the cable
`timescale 1ns/1ps
module slcc_link_partner (
    // Clock
    input  wire logic       ref_clk_i,
    // Local pairing and cable set-up
    input  wire logic       swap_ab_i,
    input  wire logic       cable_crossed_i,
    input  wire logic       plugged_i,
    input  wire logic [2:0] lag_i,
    // Line energy back to the block
    output logic            signal_detect_o = 1'b0
);
    logic [2:0] match_cnt_reg = 3'h0;

    // Energy appears lag_i + 1 cycles after the pairing matches; drops at once on mismatch
    always_ff @(posedge ref_clk_i) begin
        if (!plugged_i || (swap_ab_i != cable_crossed_i)) begin
            match_cnt_reg   <= 3'h0;
            signal_detect_o <= 1'b0;
        end else begin
            if (match_cnt_reg != lag_i) begin
                match_cnt_reg <= match_cnt_reg + 3'h1;
            end
            signal_detect_o <= (match_cnt_reg == lag_i);
        end
    end
endmodule : slcc_link_partner

/* dv/test_strap_latch_and_crossover_ctrl.sv */
// Purpose: Self-checking bench for the strap latch and crossover control top
// Assumes: Shortened hunt, negotiation and next-page counts
// Notes:   Inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
module test_strap_latch_and_crossover_ctrl;
    localparam int HUNT = 16;
    localparam int AN   = 64;
    localparam int NP   = 8;
    logic        ref_clk_i = 1'b0;
    logic        reset_i = 1'b1, soft_reset_i = 1'b0;
    logic [2:0]  receive_data_bit_zero_pin_i = 3'h0, receive_data_bit_one_pin_i = 3'h0;
    logic        crossover_auto_off_strap_i = 1'b0, crossover_force_strap_i = 1'b0;
    logic [4:0]  reg_addr_i = 5'h10;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, rd;
    logic        reg_write_i = 1'b0, signal_detect_i, gigabit_mode_i = 1'b0;
    logic        an_begin_i = 1'b0, an_done_i = 1'b0, next_page_i = 1'b0;
    logic [3:0]  station_address_o;
    logic        swap_ab_o, swap_cd_o, flp_permit_o, an_overtime_o;
    logic        crossed = 1'b0, plugged = 1'b0;
    logic [2:0]  lag = 3'h0;
    int          n_errors = 0, num_checks = 0;

    slcc_top #(.HUNT_CYCLES(HUNT), .AN_CYCLES(AN), .NP_CYCLES(NP)) slcc_top_inst (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .soft_reset_i(soft_reset_i),
        .receive_data_bit_zero_pin_i(receive_data_bit_zero_pin_i),
        .receive_data_bit_one_pin_i(receive_data_bit_one_pin_i),
        .crossover_auto_off_strap_i(crossover_auto_off_strap_i),
        .crossover_force_strap_i(crossover_force_strap_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
        .reg_rdata_o(reg_rdata_o), .signal_detect_i(signal_detect_i),
        .gigabit_mode_i(gigabit_mode_i), .an_begin_i(an_begin_i), .an_done_i(an_done_i),
        .next_page_i(next_page_i), .station_address_o(station_address_o),
        .swap_ab_o(swap_ab_o), .swap_cd_o(swap_cd_o), .flp_permit_o(flp_permit_o),
        .an_overtime_o(an_overtime_o));

    slcc_link_partner slcc_link_partner_inst (
        .ref_clk_i(ref_clk_i), .swap_ab_i(swap_ab_o), .cable_crossed_i(crossed),
        .plugged_i(plugged), .lag_i(lag), .signal_detect_o(signal_detect_i));

    // 50 MHz clock
    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // Comparator thermometer for a four-level strap mode
    function automatic logic [2:0] therm(input logic [1:0] m);
        return ~(3'h7 << m);
    endfunction : therm

    // Control word after a strap load: bit 6 auto off, bit 5 forced crossed
    function automatic logic [15:0] exp_ctrl(input logic ao, input logic fx);
        return {9'h000, ao, fx, 5'h00};
    endfunction : exp_ctrl

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_word({15'h0000, got}, {15'h0000, exp}, what);
    endtask : chk_bit

    task automatic hard_reset(input logic [1:0] m0, input logic [1:0] m1, input logic ao, input logic fx);
        @(posedge ref_clk_i);
        reset_i                     <= 1'b1;
        receive_data_bit_zero_pin_i <= therm(m0);
        receive_data_bit_one_pin_i  <= therm(m1);
        crossover_auto_off_strap_i  <= ao;
        crossover_force_strap_i     <= fx;
        repeat (6) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
    endtask : hard_reset

    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_write_i <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        d = reg_rdata_o;
    endtask : rd_reg

    task automatic soft_pulse();
        @(posedge ref_clk_i);
        soft_reset_i <= 1'b1;
        @(posedge ref_clk_i);
        soft_reset_i <= 1'b0;
    endtask : soft_pulse

    // One negotiation window with np next pages; fin ends it early
    task automatic an_run(input int np, input logic fin);
        int lim;
        lim = AN + np * NP;
        @(posedge ref_clk_i);
        an_begin_i <= 1'b1;
        @(posedge ref_clk_i);
        an_begin_i <= 1'b0;
        for (int t = 1; t < lim + 8; t++) begin
            next_page_i <= (t <= 2 * np) && t[0];
            an_done_i   <= fin && (t == 10);
            @(negedge ref_clk_i);
            if (t == 3 || t == lim - 4) chk_bit(an_overtime_o, 1'b0, "overtime early");
            @(posedge ref_clk_i);
        end
        @(negedge ref_clk_i);
        chk_bit(an_overtime_o, !fin, "overtime late");
        // Close the window, else a pending overtime set beats the next start's clear
        @(posedge ref_clk_i);
        an_done_i <= 1'b1;
        @(posedge ref_clk_i);
        an_done_i <= 1'b0;
        $display("test negotiation np=%0d fin=%0d done", np, fin);
    endtask : an_run

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // Hang guard
    initial begin
        repeat (50000) @(posedge ref_clk_i);
        n_errors++;
        $display("MISMATCH %0t run limit reached", $time);
        summarize();
    end

    initial begin
        logic [1:0]  m0, m1;
        logic [15:0] wd;
        int          w;
        w = $urandom(20);
        // Every strap mode and both two-level straps, pins stirred after the latch
        for (int i = 0; i < 4; i++) begin
            m0 = 2'(i);
            m1 = 2'(3 - i);
            hard_reset(m0, m1, i[0], i[1]);
            @(negedge ref_clk_i);
            chk_word({12'h000, station_address_o}, {12'h000, m1, m0}, "station address");
            rd_reg(5'h10, rd);
            chk_word(rd, exp_ctrl(i[0], i[1]), "control after strap load");
            @(posedge ref_clk_i);
            receive_data_bit_zero_pin_i <= therm(2'($urandom));
            receive_data_bit_one_pin_i  <= therm(2'($urandom));
            repeat (5) @(posedge ref_clk_i);
            @(negedge ref_clk_i);
            chk_word({12'h000, station_address_o}, {12'h000, m1, m0}, "address held");
        end
        $display("test straps done");
        // Software access to the control word and an unmapped place
        m0 = 2'($urandom);
        m1 = 2'($urandom);
        hard_reset(m0, m1, 1'b0, 1'b1);
        wd = 16'($urandom);
        wr_reg(5'h10, wd);
        rd_reg(5'h10, rd);
        chk_word(rd, wd, "control write");
        wr_reg(5'h03, ~wd);
        rd_reg(5'h03, rd);
        chk_word(rd, 16'h0000, "unmapped read");
        rd_reg(5'h10, rd);
        chk_word(rd, wd, "control kept");
        $display("test registers done");
        // Software reset reloads from the latch, not from the pins
        @(posedge ref_clk_i);
        receive_data_bit_zero_pin_i <= therm(~m0);
        crossover_auto_off_strap_i  <= 1'b1;
        crossover_force_strap_i     <= 1'b0;
        soft_pulse();
        @(negedge ref_clk_i);
        chk_bit(flp_permit_o, 1'b0, "permit after soft reset");
        rd_reg(5'h10, rd);
        chk_word(rd, exp_ctrl(1'b0, 1'b1), "control reloaded");
        chk_word({12'h000, station_address_o}, {12'h000, m1, m0}, "address after soft reset");
        $display("test soft reset done");
        // Automatic crossover against straight and crossed cables, no negotiation running
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk_i);
            plugged        <= 1'b0;
            crossed        <= k[0];
            gigabit_mode_i <= k[1];
            lag            <= 3'($urandom);
            soft_pulse();
            @(posedge ref_clk_i);
            plugged <= 1'b1;
            w = 0;
            while (flp_permit_o !== 1'b1 && w < 200) begin
                @(negedge ref_clk_i);
                w++;
            end
            chk_bit(w < 200, 1'b1, "crossover resolved");
            chk_bit(swap_ab_o, k[0], "pair A/B swap");
            @(negedge ref_clk_i);
            chk_bit(swap_cd_o, k[0] & k[1], "pair C/D swap");
            @(posedge ref_clk_i);
            plugged <= 1'b0;
            repeat (6) @(negedge ref_clk_i);
            chk_bit(flp_permit_o, 1'b0, "permit after loss");
        end
        $display("test automatic crossover done");
        // Forced mapping never hunts, even with the cable the other way round
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk_i);
            crossed <= !k[0];
            plugged <= 1'b1;
            wr_reg(5'h10, 16'h0040 | (16'(k) << 5));
            repeat (3) @(negedge ref_clk_i);
            chk_bit(flp_permit_o, 1'b1, "forced permit");
            chk_bit(swap_ab_o, k[0], "forced mapping");
            w = 0;
            repeat (3 * HUNT) begin
                @(negedge ref_clk_i);
                if (swap_ab_o !== k[0]) w++;
            end
            chk_bit(w == 0, 1'b1, "forced mapping held");
        end
        $display("test forced crossover done");
        an_run(0, 1'b0);
        an_run($urandom_range(1, 4), 1'b0);
        an_run(3, 1'b1);
        summarize();
    end
endmodule : test_strap_latch_and_crossover_ctrl
